// ===== rom_patch_unit.sv
`timescale 1ns/1ps
module rom_patch_unit (
   input  wire logic                       I_CLK_SYS,
   input  wire logic                       I_RST_N,
   input  wire logic [13:0]                I_AWADDR,
   input  wire logic                       I_AWVALID,
   output logic                            O_AWREADY,
   input  wire logic [31:0]                I_WDATA,
   input  wire logic [3:0]                 I_WSTRB,
   input  wire logic                       I_WVALID,
   output logic                            O_WREADY,
   output logic [1:0]                      O_BRESP,
   output logic                            O_BVALID,
   input  wire logic                       I_BREADY,
   input  wire logic [13:0]                I_ARADDR,
   input  wire logic                       I_ARVALID,
   output logic                            O_ARREADY,
   output logic [31:0]                     O_RDATA,
   output logic [1:0]                      O_RRESP,
   output logic                            O_RVALID,
   input  wire logic                       I_RREADY,
   input  wire rom_patch_pkg::fetch_req_t  I_FETCH,
   input  wire rom_patch_pkg::rd_req_t     I_RD,
   output rom_patch_pkg::jump_t            O_JUMP,
   output rom_patch_pkg::rd_rsp_t          O_RD,
   output logic                            O_PATCH_EN,
   output logic                            O_TRAP_INHIBIT
);
   typedef struct packed {
      rom_patch_pkg::bus_st_t st;
      logic                   have_aw;
      logic                   have_w;
      logic [13:0]            awaddr;
      logic [31:0]            wdata;
      logic [3:0]             wstrb;
      logic                   awready;
      logic                   wready;
      logic                   arready;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   rvalid;
      logic [1:0]             rresp;
      logic [31:0]            rdata;
      logic [4:0]             cnt;
      logic                   en;
      logic [3:0]             mode;
      rom_patch_pkg::jump_t   jump;
      rom_patch_pkg::rd_rsp_t rd;
      logic                   trap_inhibit;
   } unit_t;

   unit_t                      s;
   unit_t                      next_s;
   logic                       aw_hs;
   logic                       w_hs;
   logic                       ar_hs;
   logic [13:0]                waddr;
   logic [31:0]                wd;
   logic [3:0]                 ws;
   logic                       wr_data;
   logic [1:0]                 wsel;
   logic [1:0]                 rsel;
   rom_patch_pkg::bank_t [3:0] bank;
   logic [3:0]                 bank_valid;
   logic [3:0]                 f_hit;
   logic [3:0]                 r_hit;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [1:0] reg_sel(input logic [13:0] a);
      if (a[13:2] == rom_patch_pkg::IDX_MODE) begin
         return rom_patch_pkg::SEL_MODE;
      end else if (a[13:2] == rom_patch_pkg::IDX_STATUS) begin
         return rom_patch_pkg::SEL_STATUS;
      end else if (a[13:2] == rom_patch_pkg::IDX_DATA) begin
         return rom_patch_pkg::SEL_DATA;
      end
      return rom_patch_pkg::SEL_NONE;
   endfunction

   // merge replacement bytes into the rom word by access width
   function automatic logic [19:0] splice(input logic [19:0] rom, input logic [19:0] rep,
                                          input rom_patch_pkg::rd_size_t sz);
      logic [19:0] d;
      d = rom;
      d[7:0] = rep[7:0];
      if (sz != rom_patch_pkg::SZ_BYTE) begin
         d[15:8] = rep[15:8];
      end
      if (sz == rom_patch_pkg::SZ_20) begin
         d[19:16] = rep[19:16];
      end
      return d;
   endfunction

   // ------------------------------------------------------------
   // bank storage and comparators
   // ------------------------------------------------------------
   patch_bank_store u_store (
      .i_clk   (I_CLK_SYS),
      .i_rst_n (I_RST_N),
      .i_wr    (wr_data),
      .i_idx   (s.cnt),
      .i_byte  (wd[7:0]),
      .o_bank  (bank),
      .o_valid (bank_valid)
   );

   // one comparator per bank
   generate
      for (genvar g = 0; g < rom_patch_pkg::NUM_BANKS; g++) begin : g_match
         patch_bank_match u_match (
            .i_start      (bank[g].start),
            .i_valid      (bank_valid[g]),
            .i_fetch_addr (I_FETCH.addr),
            .i_rd_addr    (I_RD.addr),
            .o_fetch_hit  (f_hit[g]),
            .o_rd_hit     (r_hit[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // next state: bus slave, counter, patch paths
   // ------------------------------------------------------------
   always_comb begin
      next_s  = s;
      wr_data = 1'b0;
      aw_hs   = I_AWVALID && s.awready;
      w_hs    = I_WVALID && s.wready;
      ar_hs   = I_ARVALID && s.arready;
      waddr   = s.have_aw ? s.awaddr : I_AWADDR;
      wd      = s.have_w ? s.wdata : I_WDATA;
      ws      = s.have_w ? s.wstrb : I_WSTRB;
      wsel    = reg_sel(waddr);
      rsel    = reg_sel(I_ARADDR);
      unique case (s.st)
         rom_patch_pkg::ST_IDLE: begin
            if (aw_hs) begin
               next_s.have_aw = 1'b1;
               next_s.awaddr  = I_AWADDR;
            end
            if (w_hs) begin
               next_s.have_w = 1'b1;
               next_s.wdata  = I_WDATA;
               next_s.wstrb  = I_WSTRB;
            end
            if (ar_hs) begin
               next_s.st     = rom_patch_pkg::ST_RRESP;
               next_s.rvalid = 1'b1;
               next_s.rresp  = rom_patch_pkg::RESP_OKAY;
               next_s.rdata  = 32'h0; // data port reads as zero
               unique case (rsel)
                  rom_patch_pkg::SEL_MODE:   next_s.rdata[3:0] = s.mode;
                  rom_patch_pkg::SEL_STATUS: begin
                     next_s.rdata[4:0]                       = s.cnt;
                     next_s.rdata[rom_patch_pkg::STAT_EN_BIT] = s.en;
                  end
                  rom_patch_pkg::SEL_DATA:   ;
                  rom_patch_pkg::SEL_NONE:   next_s.rresp = rom_patch_pkg::RESP_SLVERR;
               endcase
            end else if (next_s.have_aw && next_s.have_w) begin
               next_s.st     = rom_patch_pkg::ST_WRESP;
               next_s.bvalid = 1'b1;
               next_s.bresp  = (wsel == rom_patch_pkg::SEL_NONE) ?
                               rom_patch_pkg::RESP_SLVERR : rom_patch_pkg::RESP_OKAY;
               if (wsel == rom_patch_pkg::SEL_MODE && ws[0]) begin
                  next_s.mode = wd[3:0];
               end
               wr_data = (wsel == rom_patch_pkg::SEL_DATA) && ws[0];
            end
         end
         rom_patch_pkg::ST_WRESP: begin
            if (I_BREADY) begin
               next_s.st      = rom_patch_pkg::ST_IDLE;
               next_s.bvalid  = 1'b0;
               next_s.have_aw = 1'b0;
               next_s.have_w  = 1'b0;
            end
         end
         rom_patch_pkg::ST_RRESP: begin
            if (I_RREADY) begin
               next_s.st     = rom_patch_pkg::ST_IDLE;
               next_s.rvalid = 1'b0;
            end
         end
      endcase
      next_s.awready = (next_s.st == rom_patch_pkg::ST_IDLE) && !next_s.have_aw;
      next_s.wready  = (next_s.st == rom_patch_pkg::ST_IDLE) && !next_s.have_w;
      next_s.arready = (next_s.st == rom_patch_pkg::ST_IDLE) && !next_s.have_aw
                       && !next_s.have_w;
      // byte counter and sticky enable
      if (wr_data) begin
         next_s.cnt = (s.cnt == rom_patch_pkg::CNT_LAST) ?
                      rom_patch_pkg::CNT_RESET : s.cnt + 5'h01;
         if (s.cnt == rom_patch_pkg::CNT_BANK0_END) begin
            next_s.en = 1'b1;
         end
      end
      // fetch and data read substitution, lowest bank wins
      next_s.jump.valid  = 1'b0;
      next_s.rd.valid    = I_RD.valid;
      next_s.rd.replaced = 1'b0;
      next_s.rd.data     = I_RD.rom_data;
      for (int b = rom_patch_pkg::NUM_BANKS - 1; b >= 0; b--) begin
         if (I_FETCH.valid && s.en && f_hit[b] && !s.mode[b]) begin
            next_s.jump.valid  = 1'b1;
            next_s.jump.target = bank[b].target;
         end
      end
      for (int b = rom_patch_pkg::NUM_BANKS - 1; b >= 0; b--) begin
         if (I_RD.valid && s.en && r_hit[b] && s.mode[b] && !I_RD.ptr_mod) begin
            next_s.rd.replaced = 1'b1;
            next_s.rd.data     = splice(I_RD.rom_data, bank[b].target, I_RD.size);
         end
      end
      next_s.trap_inhibit = s.en && I_FETCH.valid &&
                            I_FETCH.addr >= rom_patch_pkg::TRAP_FREE_LO &&
                            I_FETCH.addr <= rom_patch_pkg::TRAP_FREE_HI;
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         s      <= '0;
         s.st   <= rom_patch_pkg::ST_IDLE;
         s.cnt  <= rom_patch_pkg::CNT_RESET;
         s.mode <= rom_patch_pkg::MODE_RESET;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state register
   assign O_AWREADY      = s.awready;
   assign O_WREADY       = s.wready;
   assign O_ARREADY      = s.arready;
   assign O_BVALID       = s.bvalid;
   assign O_BRESP        = s.bresp;
   assign O_RVALID       = s.rvalid;
   assign O_RRESP        = s.rresp;
   assign O_RDATA        = s.rdata;
   assign O_JUMP         = s.jump;
   assign O_RD           = s.rd;
   assign O_PATCH_EN     = s.en;
   assign O_TRAP_INHIBIT = s.trap_inhibit;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RST_N);

   property p_cnt_inc;
      wr_data && s.cnt != rom_patch_pkg::CNT_LAST |=> s.cnt == $past(s.cnt) + 5'h01;
   endproperty
   a_cnt_inc: assert property (p_cnt_inc) else $error("counter did not step");

   property p_cnt_hold;
      !wr_data |=> $stable(s.cnt);
   endproperty
   a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved");

   property p_cnt_wrap;
      wr_data && s.cnt == 5'h17 |=> s.cnt == 5'h00;
   endproperty
   a_cnt_wrap: assert property (p_cnt_wrap) else $error("counter did not wrap");

   property p_en_set;
      !s.en && wr_data && s.cnt == 5'h05 |=> O_PATCH_EN ##1 O_PATCH_EN;
   endproperty
   a_en_set: assert property (p_en_set) else $error("enable not set");

   property p_en_sticky;
      O_PATCH_EN |=> O_PATCH_EN;
   endproperty
   a_en_sticky: assert property (p_en_sticky) else $error("enable dropped");

   property p_jump0;
      I_FETCH.valid && s.en && f_hit[0] && !s.mode[0]
      |=> O_JUMP.valid && O_JUMP.target == $past(bank[0].target);
   endproperty
   a_jump0: assert property (p_jump0) else $error("bank 0 jump missing");

   property p_no_match_unloaded;
      I_FETCH.valid && bank_valid == 4'h0 |=> !O_JUMP.valid;
   endproperty
   a_no_match_unloaded: assert property (p_no_match_unloaded) else $error("jump from empty bank");

   property p_ptr_mod;
      I_RD.valid && I_RD.ptr_mod |=> !O_RD.replaced && O_RD.data == $past(I_RD.rom_data);
   endproperty
   a_ptr_mod: assert property (p_ptr_mod) else $error("pointer read replaced");

   property p_one_byte;
      I_RD.valid && I_RD.size == rom_patch_pkg::SZ_BYTE
      |=> O_RD.data[19:8] == $past(I_RD.rom_data[19:8]);
   endproperty
   a_one_byte: assert property (p_one_byte) else $error("byte read widened");

   property p_trap;
      s.en && I_FETCH.valid && I_FETCH.addr == 20'h008bf |=> O_TRAP_INHIBIT;
   endproperty
   a_trap: assert property (p_trap) else $error("trap not inhibited");

   c_jump: cover property (O_JUMP.valid);
   c_replace: cover property (O_RD.replaced && $past(I_RD.size) == rom_patch_pkg::SZ_20);
   c_wrap: cover property (wr_data && s.cnt == 5'h17);
   c_read: cover property (O_RVALID && I_RREADY);
endmodule

// ===== rom_patch_pkg.sv
package rom_patch_pkg;
   localparam int          NUM_BANKS    = 4;
   localparam int          ADDR_W       = 20;
   localparam int          CNT_W        = 5;
   localparam int          AXI_ADDR_W   = 14;
   localparam logic [4:0]  BANK_BYTES   = 5'h06;
   localparam logic [4:0]  CNT_RESET    = 5'h00;
   localparam logic [4:0]  CNT_LAST     = 5'h17;
   localparam logic [4:0]  CNT_BANK0_END = 5'h05;
   localparam logic [3:0]  MODE_RESET   = 4'h0;
   // register indexes; byte address is four times the index
   localparam logic [11:0] IDX_MODE     = 12'hfe0;
   localparam logic [11:0] IDX_STATUS   = 12'hfe1;
   localparam logic [11:0] IDX_DATA     = 12'hfe2;
   localparam int          STAT_EN_BIT  = 8;
   localparam logic [1:0]  SEL_NONE     = 2'h0;
   localparam logic [1:0]  SEL_MODE     = 2'h1;
   localparam logic [1:0]  SEL_STATUS   = 2'h2;
   localparam logic [1:0]  SEL_DATA     = 2'h3;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   localparam logic [19:0] TRAP_FREE_LO = 20'h002c0;
   localparam logic [19:0] TRAP_FREE_HI = 20'h008bf;

   typedef enum logic [1:0] {
      SZ_BYTE = 2'h0,
      SZ_WORD = 2'h1,
      SZ_20   = 2'h2
   } rd_size_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_WRESP = 3'b010,
      ST_RRESP = 3'b100
   } bus_st_t;

   typedef struct packed {
      logic [19:0] start;
      logic [19:0] target;
   } bank_t;

   typedef struct packed {
      logic        valid;
      logic [19:0] addr;
   } fetch_req_t;

   typedef struct packed {
      logic        valid;
      logic [19:0] target;
   } jump_t;

   typedef struct packed {
      logic        valid;
      logic        ptr_mod;
      rd_size_t    size;
      logic [19:0] addr;
      logic [19:0] rom_data;
   } rd_req_t;

   typedef struct packed {
      logic        valid;
      logic        replaced;
      logic [19:0] data;
   } rd_rsp_t;
endpackage

// ===== patch_bank_match.sv
`timescale 1ns/1ps
module patch_bank_match (
   input  wire logic [19:0] i_start,
   input  wire logic        i_valid,
   input  wire logic [19:0] i_fetch_addr,
   input  wire logic [19:0] i_rd_addr,
   output logic             o_fetch_hit,
   output logic             o_rd_hit
);
   // full width compare, only for a completely loaded bank
   assign o_fetch_hit = i_valid && (i_fetch_addr == i_start);
   assign o_rd_hit    = i_valid && (i_rd_addr == i_start);
endmodule

// ===== patch_bank_store.sv
`timescale 1ns/1ps
module patch_bank_store (
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_n,
   input  wire logic                  i_wr,
   input  wire logic [4:0]            i_idx,
   input  wire logic [7:0]            i_byte,
   output rom_patch_pkg::bank_t [3:0] o_bank,
   output logic [3:0]                 o_valid
);
   typedef struct packed {
      rom_patch_pkg::bank_t [3:0] bank;
      logic [3:0]                 valid;
   } store_t;

   store_t     s;
   store_t     next_s;
   logic [4:0] bank_idx;
   logic [4:0] slot;

   // ------------------------------------------------------------
   // byte steering into the bank slots
   // ------------------------------------------------------------
   always_comb begin
      next_s   = s;
      bank_idx = i_idx / rom_patch_pkg::BANK_BYTES;
      slot     = i_idx % rom_patch_pkg::BANK_BYTES;
      for (int b = 0; b < rom_patch_pkg::NUM_BANKS; b++) begin
         if (i_wr && bank_idx == 5'(b)) begin
            unique case (slot)
               5'h0: next_s.bank[b].start[7:0]    = i_byte;
               5'h1: next_s.bank[b].start[15:8]   = i_byte;
               5'h2: next_s.bank[b].start[19:16]  = i_byte[3:0];
               5'h3: next_s.bank[b].target[7:0]   = i_byte;
               5'h4: next_s.bank[b].target[15:8]  = i_byte;
               5'h5: begin
                  next_s.bank[b].target[19:16] = i_byte[3:0];
                  next_s.valid[b]              = 1'b1;
               end
               default: ;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // storage registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign o_bank  = s.bank;
   assign o_valid = s.valid;
endmodule

// ===== cpu_side_model.sv
`timescale 1ns/1ps
// ---------------------------------------------
// cpu core fetch and data read side
// ---------------------------------------------
module cpu_side_model (
   input  wire logic                    i_fetch_go,
   input  wire logic [19:0]             i_fetch_addr,
   input  wire logic                    i_rd_go,
   input  wire logic                    i_ptr_mod,
   input  wire rom_patch_pkg::rd_size_t i_size,
   input  wire logic [19:0]             i_rd_addr,
   output rom_patch_pkg::fetch_req_t    o_fetch,
   output rom_patch_pkg::rd_req_t       o_rd
);
   // rom contents as a fixed pattern of the address
   function automatic logic [19:0] rom_word(input logic [19:0] a);
      return {a[3:0] ^ 4'h6, a[7:0] ^ 8'h5a, a[15:8] ^ a[7:0]};
   endfunction

   // fetch only at instruction starts, no idle instruction as start, replace only on
   // constant data; an idle bus shows the inverse of its last address so it never looks held
   always_comb begin
      o_fetch.valid = i_fetch_go;
      o_fetch.addr  = i_fetch_go ? i_fetch_addr : ~i_fetch_addr;
      o_rd.valid    = i_rd_go;
      o_rd.ptr_mod  = i_ptr_mod;
      o_rd.size     = i_size;
      o_rd.addr     = i_rd_go ? i_rd_addr : ~i_rd_addr;
      o_rd.rom_data = i_rd_go ? rom_word(i_rd_addr) : ~rom_word(i_rd_addr);
   end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
// ---------------------------------------------
// patch unit bench with reference model
// ---------------------------------------------
module tb;
   localparam logic [13:0] A_MODE = {rom_patch_pkg::IDX_MODE, 2'b00};
   localparam logic [13:0] A_STAT = {rom_patch_pkg::IDX_STATUS, 2'b00};
   localparam logic [13:0] A_DATA = {rom_patch_pkg::IDX_DATA, 2'b00};
   logic                      clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic                      f_go, r_go, ptr, awready, wready, bvalid, arready, rvalid;
   logic                      patch_en, trap_inh;
   logic [13:0]               awaddr, araddr;
   logic [31:0]               wdata, rdata;
   logic [3:0]                wstrb;
   logic [19:0]               f_addr, r_addr, st, tg;
   logic [1:0]                bresp, rresp;
   logic [15:0]               seed;
   rom_patch_pkg::rd_size_t   sz;
   rom_patch_pkg::fetch_req_t fetch;
   rom_patch_pkg::rd_req_t    rd;
   rom_patch_pkg::jump_t      jump;
   rom_patch_pkg::rd_rsp_t    rsp;
   int                        errors, n_checks, m_cnt, m_en, m_mode, m_start[4], m_tgt[4];
   int                        m_valid[4];

   rom_patch_unit rom_patch_unit_inst (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_AWADDR(awaddr),
      .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb),
      .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
      .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
      .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
      .I_FETCH(fetch), .I_RD(rd), .O_JUMP(jump), .O_RD(rsp), .O_PATCH_EN(patch_en),
      .O_TRAP_INHIBIT(trap_inh));
   cpu_side_model cpu_side_model_inst (.i_fetch_go(f_go), .i_fetch_addr(f_addr),
      .i_rd_go(r_go), .i_ptr_mod(ptr), .i_size(sz), .i_rd_addr(r_addr), .o_fetch(fetch),
      .o_rd(rd));

   // system clock, 10 ns
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [19:0] rom_exp(input logic [19:0] a);
      return {a[3:0] ^ 4'h6, a[7:0] ^ 8'h5a, a[15:8] ^ a[7:0]};
   endfunction

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ---------------------------------------------
   // bus master tasks
   // ---------------------------------------------
   task automatic axw(input logic [13:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (n == 50) errors++;
      if (n == 50) final_report();
      chk("bresp", bresp, er);
   endtask

   task automatic axr(input logic [13:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      if (n == 50) errors++;
      if (n == 50) final_report();
      chk("rdata", rdata, ed);
      chk("rresp", rresp, er);
   endtask

   // one data port byte, model update, then counter and enable readback
   task automatic put_byte(input logic [7:0] b);
      int bk;
      int k;
      axw(A_DATA, {24'h0, b}, rom_patch_pkg::RESP_OKAY);
      bk = m_cnt / 6;
      k = m_cnt % 6;
      if (k < 3) m_start[bk][8*k +: 8] = (k == 2) ? b & 8'h0f : b;
      else m_tgt[bk][8*(k-3) +: 8] = (k == 5) ? b & 8'h0f : b;
      if (k == 5) m_valid[bk] = 1;
      if (k == 5) m_en = 1;
      m_cnt = (m_cnt + 1) % 24;
      axr(A_STAT, m_cnt | (m_en << 8), rom_patch_pkg::RESP_OKAY);
   endtask

   // fetch and data read in one cycle, answers checked one cycle later
   task automatic op(input logic [19:0] fa, input logic [19:0] ra, input int s, input logic p);
      int bk;
      int jb;
      int rb;
      logic [19:0] ex;
      @(posedge clk);
      f_addr <= fa;
      r_addr <= ra;
      sz <= rom_patch_pkg::rd_size_t'(s);
      ptr <= p;
      f_go <= 1'b1;
      r_go <= 1'b1;
      @(posedge clk);
      f_go <= 1'b0;
      r_go <= 1'b0;
      #1;
      jb = -1;
      rb = -1;
      for (bk = 3; bk >= 0; bk--) begin
         if (m_en && m_valid[bk] && m_start[bk] == fa && !m_mode[bk]) jb = bk;
         if (m_en && m_valid[bk] && m_start[bk] == ra && m_mode[bk] && !p) rb = bk;
      end
      ex = rom_exp(ra);
      if (rb >= 0 && s == 0) ex[7:0] = m_tgt[rb][7:0];
      if (rb >= 0 && s == 1) ex[15:0] = m_tgt[rb][15:0];
      if (rb >= 0 && s == 2) ex = m_tgt[rb][19:0];
      chk("jump_valid", jump.valid, jb >= 0);
      if (jb >= 0) chk("jump_target", jump.target, m_tgt[jb]);
      chk("trap_inhibit", trap_inh, m_en && fa >= 20'h002c0 && fa <= 20'h008bf);
      chk("patch_en", patch_en, m_en != 0);
      chk("rd_valid", rsp.valid, 1'b1);
      chk("rd_replaced", rsp.replaced, rb >= 0);
      chk("rd_data", rsp.data, ex);
   endtask

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      {rst_n, awvalid, wvalid, bready, arvalid, rready, f_go, r_go, ptr} = '0;
      {awaddr, araddr, wdata, f_addr, r_addr} = '0;
      wstrb = 4'hf;
      sz = rom_patch_pkg::SZ_BYTE;
      seed = 16'h0042;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      axr(A_STAT, 32'h0, rom_patch_pkg::RESP_OKAY);
      axr(A_MODE, 32'h0, rom_patch_pkg::RESP_OKAY);
      op(20'h002c0, 20'h00100, 0, 1'b0);
      // banks far apart, last byte of each preceded by a probe at its start
      for (int b = 0; b < 4; b++) begin
         seed = lfsr(seed);
         st = {b[1:0], seed, 2'b00};
         seed = lfsr(seed);
         tg = {seed[3:0], lfsr(seed)};
         for (int k = 0; k < 6; k++) begin
            if (k == 5) op(st, st, 2, 1'b0);
            put_byte(k < 3 ? 8'(({4'h0, st}) >> (8*k)) : 8'(({4'h0, tg}) >> (8*(k-3))));
         end
      end
      axw(A_MODE, 32'hfffffffa, rom_patch_pkg::RESP_OKAY);
      m_mode = 32'ha;
      axr(A_MODE, 32'ha, rom_patch_pkg::RESP_OKAY);
      // a write without byte lane 0 must leave the mode bits alone
      wstrb <= 4'he;
      axw(A_MODE, 32'h5, rom_patch_pkg::RESP_OKAY);
      wstrb <= 4'hf;
      axr(A_MODE, 32'ha, rom_patch_pkg::RESP_OKAY);
      for (int b = 0; b < 4; b++) begin
         for (int s = 0; s < 3; s++) begin
            op(20'(m_start[b]), 20'(m_start[b]), s, 1'b0);
            op(20'(m_start[b] + 1), 20'(m_start[b] + 1), s, 1'b0);
            op(20'(m_start[b]), 20'(m_start[b]), s, 1'b1);
         end
      end
      foreach (m_tgt[i]) op(20'h002c0 + 20'(i[0] ? 12'h5ff : 12'h000) + 20'(i[1]), 20'h0, 0, 1'b0);
      op(20'h002bf, 20'h0, 0, 1'b0);
      op(20'h008c0, 20'h0, 0, 1'b0);
      repeat (8) begin
         seed = lfsr(seed);
         op({seed[3:0], lfsr(seed)}, {seed, 4'h0}, seed[1:0] % 3, seed[2]);
      end
      axw(A_STAT, 32'h0, rom_patch_pkg::RESP_OKAY);
      axr(A_STAT, 32'h100, rom_patch_pkg::RESP_OKAY);
      axr(A_DATA, 32'h0, rom_patch_pkg::RESP_OKAY);
      axw(14'h0010, 32'h1, rom_patch_pkg::RESP_SLVERR);
      axr(14'h0010, 32'h0, rom_patch_pkg::RESP_SLVERR);
      put_byte(8'h77);
      op(20'(m_start[0]), 20'(m_start[0]), 0, 1'b0);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      {m_cnt, m_en, m_mode} = '0;
      m_valid = '{0, 0, 0, 0};
      repeat (2) @(posedge clk);
      axr(A_STAT, 32'h0, rom_patch_pkg::RESP_OKAY);
      op(20'(m_start[1]), 20'(m_start[1]), 1, 1'b0);
      final_report();
   end

   // overall guard against a hang
   initial begin
      #900us;
      errors++;
      final_report();
   end
endmodule
